// *** verilog/ioc_pkg.sv ***
// Purpose: shared constants and types for the interrupt output block
// Assumes: 40 MHz system clock, AXI4-Lite register access
// Notes:   offsets are byte addresses
package ioc_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] IOC_OFS_CONFIG   = 12'h054; // output config
	localparam logic [11:0] IOC_OFS_STATUS   = 12'h058; // source status
	localparam logic [11:0] IOC_OFS_ENABLE   = 12'h05C; // source enable
	localparam logic [11:0] IOC_OFS_EVSTAT   = 12'h060; // sticky events
	localparam logic [11:0] IOC_OFS_EVMASK   = 12'h064; // event mask
	// ----------------------------------------------------------------
	// config field positions, power source bit and status mask
	// ----------------------------------------------------------------
	localparam int IOC_DEAS_MSB      = 31; // interval high bit
	localparam int IOC_DEAS_LSB      = 24; // interval low bit
	localparam int IOC_RESTART_BIT   = 14; // interval restart
	localparam int IOC_ACTIVE_BIT    = 13; // interval in progress
	localparam int IOC_MASTER_BIT    = 12; // combined line
	localparam int IOC_EN_BIT        = 8;  // output enable
	localparam int IOC_POL_BIT       = 4;  // output polarity
	localparam int IOC_TYPE_BIT      = 0;  // buffer type
	localparam int IOC_PWR_BIT       = 17; // power event source
	localparam logic [31:0] IOC_STATUS_MASK = 32'hFFBBFFFF; // wired bits
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int IOC_CLK_HZ        = 40000000; // system clock
	localparam int IOC_TICK_US       = 10;       // interval step
	localparam int IOC_TICK_CYC      = IOC_CLK_HZ / 1000000 * IOC_TICK_US;
	localparam logic [8:0] IOC_TICK_LAST = 9'(IOC_TICK_CYC - 1);
	// ----------------------------------------------------------------
	// event bits and bus answers
	// ----------------------------------------------------------------
	localparam int IOC_EV_ASSERT     = 0; // pin went active
	localparam int IOC_EV_EXPIRE     = 1; // interval ended
	localparam int IOC_EV_W          = 2; // event count
	localparam logic [1:0] IOC_RESP_OKAY   = 2'h0; // good access
	localparam logic [1:0] IOC_RESP_SLVERR = 2'h2; // unmapped
	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] deassert_interval; // hold-off in 10 us steps
		logic       irq_enable;        // output enable
		logic       output_polarity;   // 1 = active high
		logic       push_pull;         // 1 = push-pull
	} ioc_cfg_type;
	typedef struct packed {
		logic o;  // pin level driven
		logic oe; // pin driven
	} ioc_pin_type;
	typedef enum logic [1:0] {IOC_IDLE, IOC_READ, IOC_WRITE} ioc_bus_type;
endpackage

// *** verilog/ioc_holdoff.sv ***
// Purpose: hold-off interval counter with its 10 us tick divider
// Assumes: one clock, synchronous active-low reset
// Notes:   a zero interval disables gating entirely
`timescale 1ns/1ps
`default_nettype none
module ioc_holdoff
	import ioc_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	// control
	input  wire logic [7:0] interval_i,  // programmed interval
	input  wire logic       zero_wr_i,   // zero written this cycle
	input  wire logic       restart_i,   // fresh interval request
	input  wire logic       start_i,     // pin deasserted, begin
	// status
	output logic            active_o,    // interval in progress
	output logic            expire_o     // one-cycle end pulse
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [8:0] div, next_div;     // tick divider
	logic [7:0] cnt, next_cnt;     // elapsed ticks
	logic       act, next_act;     // interval running
	logic       exp, next_exp;     // expiry pulse
	logic       tick;              // 10 us enable pulse

	// divider only runs while an interval runs
	assign tick = act && (div == IOC_TICK_LAST);

	// next state of interval counter
	always_comb begin
		next_div = div;
		next_cnt = cnt;
		next_act = act;
		next_exp = 1'b0;
		if (zero_wr_i || interval_i == 8'h00) begin
			// disabled: clear and release
			next_div = 9'h000; // RL2
			next_cnt = 8'h00;
			next_act = 1'b0;
			next_exp = act;
		end else if (restart_i || start_i) begin
			// fresh interval, even if already running
			next_div = 9'h000; // RL5
			next_cnt = 8'h00;
			next_act = 1'b1;
		end else if (act) begin
			next_div = tick ? 9'h000 : 9'(div + 9'h001); // RL14
			if (tick) begin
				next_cnt = 8'(cnt + 8'h01);
				// current setting used for the compare
				if (8'(cnt + 8'h01) >= interval_i) begin // RL3
					next_act = 1'b0; // RL14
					next_exp = 1'b1;
				end
			end
		end
	end

	// register interval state
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			div <= 9'h000;
			cnt <= 8'h00;
			act <= 1'b0;
			exp <= 1'b0;
		end else begin
			div <= next_div;
			cnt <= next_cnt;
			act <= next_act;
			exp <= next_exp;
		end
	end

	assign active_o = act;
	assign expire_o = exp;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_zero_clears: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		zero_wr_i |=> !act) else $error("zero write left interval on"); // RL2
	a_restart_runs: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(restart_i && !zero_wr_i && interval_i != 8'h00)
		|=> act && cnt == 8'h00 && div == 9'h000)
		else $error("restart did not begin interval"); // RL5
	// each step of a running interval advances the elapsed count once
	a_tick_advance: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(tick && !zero_wr_i && !restart_i && !start_i && interval_i != 8'h00)
		|=> cnt == 8'($past(cnt) + 8'h01))
		else $error("tick did not advance interval"); // RL14
endmodule
`default_nettype wire

// *** verilog/ioc_top.sv ***
// Purpose: interrupt request output configuration and pin driver
// Assumes: AXI4-Lite slave, 40 MHz clock, sources on one clock
// Notes:   pin is two signals; bench resolves the wire
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RL1] eight-bit interval, 10 us units, reset zero
// [RL2] zero interval disables, clears, releases pending
// [RL3] new interval applies to later interrupts
// [RL4] power event source bypasses hold-off gating
// [RL5] restart bit starts fresh interval, self-clears
// [RL6] active flag shown; blocks pin while set
// [RL7] master bit shows combined enabled line
// [RL8] output enable zero keeps pin inactive
// [RL9] polarity bit selects active low or high
// [RL10] buffer bit selects open-drain or push-pull
// [RL11] open-drain ignores polarity, asserts low
// [RL12] kept bits survive soft resets
// [RL13] status write-one clears; raw status reported
// [RL14] 10 us tick counts interval; expiry releases
// [RL15] reserved bits read zero, writes ignored
module ioc_top
	import ioc_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        soft_rst_i,      // soft reset pulse
	// interrupt sources (same clock)
	input  wire logic [31:0] src_event_i,     // one-cycle set pulses
	// axi4-lite write address
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// interrupt pin and block interrupt
	output logic             irq_pin_o,       // level when driven
	output logic             irq_pin_oe_o,    // high while driven
	output logic             irq_o            // block event interrupt
);
	// ----------------------------------------------------------------
	// byte-lane merge
	// ----------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) r[i*8 +: 8] = data[i*8 +: 8];
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	ioc_cfg_type   cfg, next_cfg;            // kept over soft reset
	logic [31:0]   status, next_status;      // raw source status
	logic [31:0]   enable, next_enable;      // per-source enable
	logic [IOC_EV_W-1:0] evstat, next_evstat; // sticky events
	logic [IOC_EV_W-1:0] evmask, next_evmask; // event mask
	ioc_pin_type   pin, next_pin;            // registered pin
	logic          pin_act, next_pin_act;    // pin asserted last
	ioc_bus_type   bstate, next_bstate;      // bus phase
	logic          aw_held, next_aw_held;    // address captured
	logic          w_held, next_w_held;      // data captured
	logic [11:0]   waddr, next_waddr;        // write address
	logic [31:0]   wdata, next_wdata;        // write data
	logic [3:0]    wstrb, next_wstrb;        // write strobes
	logic [31:0]   rdata, next_rdata;        // read data
	logic [1:0]    resp, next_resp;          // response code
	// combinational helpers
	logic          wr_fire;                  // write performed
	logic          rd_fire;                  // read address taken
	logic [31:0]   cfg_word;                 // assembled config read
	logic [31:0]   cfg_new;                  // merged config write
	logic [31:0]   evmask_wr;                // merged mask write
	logic          zero_wr;                  // interval written zero
	logic          restart;                  // restart bit written
	logic          master;                   // combined enabled line
	logic          gated;                    // non-power sources
	logic          pwr;                      // power event source
	logic          want;                     // pin should assert
	logic          hold_act;                 // interval running
	logic          hold_exp;                 // interval ended
	logic [IOC_EV_W-1:0] ev_set;             // event pulses

	// ----------------------------------------------------------------
	// hold-off counter
	// ----------------------------------------------------------------
	ioc_holdoff u_holdoff (
		.clk_i      (clk_i),
		.rst_b_i    (rst_b_i),
		.interval_i (cfg.deassert_interval),
		.zero_wr_i  (zero_wr),
		.restart_i  (restart),
		.start_i    (pin_act && !want),
		.active_o   (hold_act),
		.expire_o   (hold_exp)
	);

	// ----------------------------------------------------------------
	// interrupt combine
	// ----------------------------------------------------------------
	assign master = |(status & enable);                         // RL7
	assign pwr    = status[IOC_PWR_BIT] & enable[IOC_PWR_BIT];
	assign gated  = |(status & enable & ~(32'h1 << IOC_PWR_BIT));
	// hold-off blocks all but the power event
	assign want   = cfg.irq_enable &&                           // RL8
		(pwr || (gated && !hold_act));                            // RL4 RL6
	assign ev_set = {hold_exp, want && !pin_act};

	// config read word, reserved bits zero
	always_comb begin
		cfg_word = 32'h0; // RL15
		cfg_word[IOC_DEAS_MSB:IOC_DEAS_LSB] = cfg.deassert_interval; // RL1
		cfg_word[IOC_ACTIVE_BIT] = hold_act; // RL6
		cfg_word[IOC_MASTER_BIT] = master;   // RL7
		cfg_word[IOC_EN_BIT]     = cfg.irq_enable;
		cfg_word[IOC_POL_BIT]    = cfg.output_polarity;
		cfg_word[IOC_TYPE_BIT]   = cfg.push_pull;
	end

	// ----------------------------------------------------------------
	// bus handshake
	// ----------------------------------------------------------------
	assign s_axi_awready = (bstate == IOC_IDLE) && !aw_held && !s_axi_arvalid;
	assign s_axi_wready  = (bstate == IOC_IDLE) && !w_held && !s_axi_arvalid;
	assign s_axi_arready = (bstate == IOC_IDLE) && !aw_held && !w_held;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign wr_fire = (bstate == IOC_IDLE) && aw_held && w_held;
	assign cfg_new = merge(cfg_word, wdata, wstrb);
	assign evmask_wr = merge({30'h0, evmask}, wdata, wstrb);
	assign zero_wr = wr_fire && waddr == IOC_OFS_CONFIG && wstrb[3] &&
		cfg_new[IOC_DEAS_MSB:IOC_DEAS_LSB] == 8'h00;
	assign restart = wr_fire && waddr == IOC_OFS_CONFIG &&
		cfg_new[IOC_RESTART_BIT]; // RL5

	// next bus state and register updates
	always_comb begin
		next_bstate  = bstate;
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_waddr   = waddr;
		next_wdata   = wdata;
		next_wstrb   = wstrb;
		next_rdata   = rdata;
		next_resp    = resp;
		next_cfg     = cfg;
		next_enable  = enable;
		next_evmask  = evmask;
		// sources set; set wins over write clear, soft reset clears regardless
		next_status  = status | (src_event_i & IOC_STATUS_MASK);
		next_evstat  = evstat;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_waddr   = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_wdata  = s_axi_wdata;
			next_wstrb  = s_axi_wstrb;
		end
		case (bstate)
			IOC_IDLE: begin
				if (wr_fire) begin
					next_bstate  = IOC_WRITE;
					next_aw_held = 1'b0;
					next_w_held  = 1'b0;
					next_resp    = IOC_RESP_OKAY;
					case (waddr)
						IOC_OFS_CONFIG: begin
							// only writable fields taken
							next_cfg.deassert_interval =
								cfg_new[IOC_DEAS_MSB:IOC_DEAS_LSB]; // RL1 RL3
							next_cfg.irq_enable      = cfg_new[IOC_EN_BIT];
							next_cfg.output_polarity = cfg_new[IOC_POL_BIT];
							next_cfg.push_pull       = cfg_new[IOC_TYPE_BIT];
						end
						IOC_OFS_STATUS: begin
							// write one clears, new events win
							next_status = (status & ~merge(32'h0, wdata, wstrb))
								| (src_event_i & IOC_STATUS_MASK); // RL13
						end
						IOC_OFS_ENABLE: next_enable =
							merge(enable, wdata, wstrb) & IOC_STATUS_MASK;
						IOC_OFS_EVMASK: next_evmask =
							evmask_wr[IOC_EV_W-1:0];
						IOC_OFS_EVSTAT: ; // read-clear only
						default: next_resp = IOC_RESP_SLVERR;
					endcase
				end else if (rd_fire) begin
					next_bstate = IOC_READ;
					next_resp   = IOC_RESP_OKAY;
					case (s_axi_araddr)
						IOC_OFS_CONFIG: next_rdata = cfg_word;
						IOC_OFS_STATUS: next_rdata = status; // RL13
						IOC_OFS_ENABLE: next_rdata = enable;
						IOC_OFS_EVSTAT: begin
							next_rdata  = {30'h0, evstat};
							next_evstat = 2'h0; // read clears
						end
						IOC_OFS_EVMASK: next_rdata = {30'h0, evmask};
						default: begin
							next_rdata = 32'h0;
							next_resp  = IOC_RESP_SLVERR;
						end
					endcase
				end
			end
			IOC_WRITE: if (s_axi_bready) next_bstate = IOC_IDLE;
			IOC_READ:  if (s_axi_rready) next_bstate = IOC_IDLE;
			default:   next_bstate = IOC_IDLE;
		endcase
		next_evstat = next_evstat | ev_set; // set wins over read clear
		// soft reset clears status, enable and event registers; keeps the config
		if (soft_rst_i) begin
			next_status = 32'h0;
			next_enable = 32'h0;
			next_evstat = 2'h0;
			next_evmask = 2'h0;
			next_cfg    = cfg; // RL12
		end
	end

	// next pin drive
	always_comb begin
		next_pin_act = want;
		if (!cfg.push_pull) begin
			// open drain: pull low only when active
			next_pin.o  = 1'b0;          // RL10 RL11
			next_pin.oe = want;
		end else begin
			next_pin.o  = want ~^ cfg.output_polarity; // RL9
			next_pin.oe = 1'b1;
			if (!want) next_pin.o = !cfg.output_polarity;
			else       next_pin.o = cfg.output_polarity;
		end
	end

	// register all state
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			cfg     <= '0;
			status  <= 32'h0;
			enable  <= 32'h0;
			evstat  <= 2'h0;
			evmask  <= 2'h0;
			pin     <= '0;
			pin_act <= 1'b0;
			bstate  <= IOC_IDLE;
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			waddr   <= 12'h000;
			wdata   <= 32'h0;
			wstrb   <= 4'h0;
			rdata   <= 32'h0;
			resp    <= 2'h0;
		end else begin
			cfg     <= next_cfg;
			status  <= next_status;
			enable  <= next_enable;
			evstat  <= next_evstat;
			evmask  <= next_evmask;
			pin     <= next_pin;
			pin_act <= next_pin_act;
			bstate  <= next_bstate;
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			waddr   <= next_waddr;
			wdata   <= next_wdata;
			wstrb   <= next_wstrb;
			rdata   <= next_rdata;
			resp    <= next_resp;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign irq_pin_o    = pin.o;
	assign irq_pin_oe_o = pin.oe;
	assign irq_o        = |(evstat & evmask);
	assign s_axi_bvalid = (bstate == IOC_WRITE);
	assign s_axi_bresp  = resp;
	assign s_axi_rvalid = (bstate == IOC_READ);
	assign s_axi_rresp  = resp;
	assign s_axi_rdata  = rdata;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_disabled;
		!cfg.irq_enable;
	endsequence
	a_enable_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_disabled ##1 s_disabled |-> !pin_act) else $error("pin active while off"); // RL8
	a_od_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(!cfg.push_pull && !$past(cfg.push_pull)) |-> !pin.o)
		else $error("open drain drove high"); // RL11
	a_od_release: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(!cfg.push_pull && !$past(cfg.push_pull) && !pin_act) |-> !pin.oe)
		else $error("open drain driven while idle"); // RL10
	a_pp_polarity: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(cfg.push_pull && $past(cfg.push_pull) &&
		$stable(cfg.output_polarity)) |->
		pin.oe && (pin.o == (pin_act ~^ cfg.output_polarity)))
		else $error("push-pull level wrong"); // RL9
	a_hold_block: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(hold_act && !pwr) |=> !pin_act) else $error("held interrupt passed"); // RL6
	a_power_bypass: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(pwr && cfg.irq_enable) |=> pin_act) else $error("power event gated"); // RL4
	a_status_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wr_fire && waddr == IOC_OFS_STATUS && !soft_rst_i &&
		wstrb[0] && wdata[0] && !src_event_i[0]) |=> !status[0])
		else $error("status write did not clear"); // RL13
	a_kept_cfg: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		soft_rst_i |=> $stable(cfg)) else $error("config lost on soft reset"); // RL12
endmodule
`default_nettype wire

// *** verif/ioc_host_line.sv ***
// Purpose: host side of the interrupt line, resolves the shared wire
// Assumes: board pull-up on the line
// Notes:   released or open-drain high reads as the pull-up level
`timescale 1ns/1ps
`default_nettype none
module ioc_host_line (
	// split device pin
	input  wire logic pin_i,  // level when driven
	input  wire logic oe_i,   // high while driven
	// wire as the host input sees it
	output logic      line_o  // resolved level
);
	// released wire floats to the pull-up
	always_comb begin
		line_o = oe_i ? pin_i : 1'b1;
	end
endmodule
`default_nettype wire

// *** verif/irq_output_config_tb.sv ***
// Purpose: self-checking bench for the interrupt output block
// Assumes: 40 MHz clock, AXI4-Lite master tasks, host line model
// Notes:   expected pin levels come from the config model m_cfg
`timescale 1ns/1ps
`default_nettype none
module irq_output_config_tb;
	import ioc_pkg::*;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic        clk_i = 1'b0, rst_b_i = 1'b0, soft_rst_i = 1'b0;
	logic [31:0] src_event_i = '0, s_axi_wdata = '0, s_axi_rdata;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
	logic        irq_pin_o, irq_pin_oe_o, irq_o, host_line;
	logic [31:0] rd_v, rnd;                     // read result, random
	int          miscompares = 0, compares = 0; // verdict counters
	int          cycles = 0, hits = 0, m_cfg = 0; // timeout, model
	logic [31:0] modes [4] = '{32'h100, 32'h110, 32'h101, 32'h111};
	always #12.5 clk_i = ~clk_i; // 25 ns period
	ioc_top DUT (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.soft_rst_i(soft_rst_i), .src_event_i(src_event_i),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .irq_pin_o(irq_pin_o),
		.irq_pin_oe_o(irq_pin_oe_o), .irq_o(irq_o));
	ioc_host_line HOST (.pin_i(irq_pin_o), .oe_i(irq_pin_oe_o),
		.line_o(host_line));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// compare one value, count and report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// pin level for a given interrupt state under the model config
	function automatic logic line_exp(input logic act);
		if (!m_cfg[8]) act = 1'b0;
		return m_cfg[0] ? (act ~^ m_cfg[4]) : !act;
	endfunction
	// bus write, address and data offered together
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		forever begin
			@(posedge clk_i);
			if (!aw && !w && s_axi_bvalid) begin
				chk(32'(s_axi_bresp), 32'(IOC_RESP_OKAY));
				s_axi_bready <= 1'b0;
				break;
			end
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
			// ready for the answer once both halves are taken
			if (!aw && !w) s_axi_bready <= 1'b1;
		end
		if (a == IOC_OFS_CONFIG) m_cfg = d & 32'hFF000111; // writable bits
	endtask
	// bus read into rd_v and rd_r
	task automatic rd(input logic [11:0] a);
		logic ar;
		ar = 1'b1;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		forever begin
			@(posedge clk_i);
			if (!ar && s_axi_rvalid) begin
				rd_v = s_axi_rdata;
				rd_r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
			if (ar && s_axi_arready) begin
				ar = 1'b0;
				s_axi_arvalid <= 1'b0;
				s_axi_rready <= 1'b1;
			end
		end
	endtask
	// one-cycle source pulse
	task automatic pulse(input logic [31:0] v);
		src_event_i <= v;
		@(posedge clk_i);
		src_event_i <= '0;
	endtask
	// bounded wait for a host line level, then compare
	task automatic wait_line(input logic exp, input int n);
		for (int i = 0; i < n && host_line !== exp; i++) @(posedge clk_i);
		chk(32'(host_line), 32'(exp));
	endtask
	// hang guard
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			finish_test();
		end
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32));
		repeat (20) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		rd(IOC_OFS_CONFIG);
		chk(rd_v, 32'h00000000);
		rd(12'h100);
		chk(32'(rd_r), 32'(IOC_RESP_SLVERR));
		wr(IOC_OFS_CONFIG, 32'h00FF8EEE);
		rd(IOC_OFS_CONFIG);
		chk(rd_v, 32'h00000000);
		// random sources with nothing enabled
		rnd = $urandom;
		pulse(rnd);
		rd(IOC_OFS_STATUS);
		chk(rd_v, rnd & IOC_STATUS_MASK);
		rd(IOC_OFS_CONFIG);
		chk(rd_v, 32'h00000000);
		wr(IOC_OFS_STATUS, 32'hFFFFFFFF);
		rd(IOC_OFS_STATUS);
		chk(rd_v, 32'h00000000);
		// enabled source, output still off
		wr(IOC_OFS_ENABLE, 32'h00020001);
		wr(IOC_OFS_EVMASK, 32'h00000003);
		pulse(32'h00000001);
		rd(IOC_OFS_CONFIG);
		chk(rd_v, 32'h00001000);
		chk(32'(host_line), 32'(line_exp(1'b1)));
		foreach (modes[i]) begin
			wr(IOC_OFS_CONFIG, modes[i]);
			wait_line(line_exp(1'b1), 5);
		end
		// event interrupt: masked, unmasked, read clear
		chk(32'(irq_o), 32'h1);
		wr(IOC_OFS_EVMASK, 32'h0);
		chk(32'(irq_o), 32'h0);
		wr(IOC_OFS_EVMASK, 32'h3);
		rd(IOC_OFS_EVSTAT);
		chk(rd_v, 32'h1);
		rd(IOC_OFS_EVSTAT);
		chk(rd_v, 32'h0);
		chk(32'(irq_o), 32'h0);
		// hold-off of two steps after deassertion
		wr(IOC_OFS_CONFIG, 32'h02000111);
		wr(IOC_OFS_STATUS, 32'h00000001);
		wait_line(line_exp(1'b0), 5);
		rd(IOC_OFS_CONFIG);
		chk(rd_v, 32'h02002111);
		pulse(32'h00000001);
		repeat (IOC_TICK_CYC - 50) begin
			@(posedge clk_i);
			if (host_line === line_exp(1'b1)) hits++;
		end
		chk(32'(hits), 32'h0);
		wait_line(line_exp(1'b1), 2 * IOC_TICK_CYC + 100);
		rd(IOC_OFS_EVSTAT);
		chk(rd_v, 32'h3);
		// power event bypass, restart, zero interval release
		wr(IOC_OFS_STATUS, 32'h00000001);
		wait_line(line_exp(1'b0), 5);
		pulse(32'h00020000);
		wait_line(line_exp(1'b1), 5);
		wr(IOC_OFS_STATUS, 32'h00020000);
		pulse(32'h00000001);
		wr(IOC_OFS_CONFIG, 32'h02004111);
		rd(IOC_OFS_CONFIG);
		chk(rd_v, 32'h02003111);
		chk(32'(host_line), 32'(line_exp(1'b0)));
		wr(IOC_OFS_CONFIG, 32'h00000111);
		wait_line(line_exp(1'b1), 5);
		rd(IOC_OFS_CONFIG);
		chk(rd_v, 32'h00001111);
		// soft reset keeps the config
		soft_rst_i <= 1'b1;
		@(posedge clk_i);
		soft_rst_i <= 1'b0;
		rd(IOC_OFS_CONFIG);
		chk(rd_v, 32'h00000111);
		wait_line(line_exp(1'b0), 5);
		finish_test();
	end
endmodule
`default_nettype wire
